// *** logic/ai_timing_engine.sv ***
// One analog input timing engine: triggers, sample clock, convert pulses, buffer
`timescale 1ns/1ns
module ai_timing_engine
	import ai_timing_pkg::*;
#(
	parameter int ENGINE_INDEX = 0,
	parameter int NUM_TERMS = 8,
	parameter int BUF_DEPTH = FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire cfg_t cfg,
	input wire logic commit,
	input wire logic sw_start,
	input wire logic sw_stop,
	input wire logic [NUM_TERMS-1:0] terminal_in,
	input wire logic counter_out,
	input wire logic analog_event,
	input wire logic timebase_in,
	input wire logic [TIME_W-1:0] device_time,
	input wire route_t [NUM_TERMS-1:0] term_route,
	output logic [NUM_TERMS-1:0] terminal_out,
	output logic sample_clock,
	output logic start_trig_out,
	output logic ref_trig_out,
	output logic convert_pulse,
	output logic [CH_W-1:0] convert_chan,
	output logic ssh_sample,
	output logic dsm_sync,
	output oversample_t os_sel,
	output logic slow_convert,
	output logic slow_reuse,
	input wire logic adc_valid,
	output logic adc_ready,
	input wire logic [SAMPLE_W-1:0] adc_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [SAMPLE_W-1:0] out_data,
	output status_t status
);
	localparam int NS = NUM_TERMS + EXTRA_INPUTS;

	initial begin
		if (ENGINE_INDEX < 0 || ENGINE_INDEX >= NUM_ENGINES)
			$error("ai_timing_engine: engine index out of range");
		if (NUM_TERMS < 1 || NUM_TERMS > (1 << TERM_W))
			$error("ai_timing_engine: unsupported terminal count");
	end

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_START,
		ST_DELAY,
		ST_RUN,
		ST_POST,
		ST_DONE
	} fsm_t;

	typedef struct packed {
		logic [NS-1:0] s1;
		logic [NS-1:0] s2;
		logic [NS-1:0] s3;
		fsm_t fsm;
		logic [CNT_W-1:0] tb_cnt;
		logic [CNT_W-1:0] delay_cnt;
		logic [CNT_W-1:0] smp_cnt;
		logic [CNT_W-1:0] pre_cnt;
		logic [CNT_W-1:0] post_cnt;
		logic ref_armed;
		logic triggered;
		logic paused;
		logic [CH_W-1:0] conv_left;
		logic [CNT_W-1:0] conv_cnt;
		logic [CNT_W-1:0] conv_gap;
		logic [CNT_W-1:0] slow_cnt;
		logic sc_pulse;
		logic st_pulse;
		logic rt_pulse;
		logic conv_pulse;
		logic [CH_W-1:0] conv_chan;
		logic ssh_pulse;
		logic sync_pulse;
		oversample_t os_sel;
		logic slow_conv;
		logic slow_reuse;
		logic [NUM_TERMS-1:0] term_out;
	} state_t;

	state_t q, d;
	logic [1:0] rst_q;
	logic rst_n_s;
	logic [NS-1:0] rise, fall;
	logic acquiring, fifo_full, discard, fifo_valid, fifo_in_ready;

	// Reset release through two flops
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'h1};
	end
	assign rst_n_s = rst_q[1];

	// Pick a synchronised bit by source and terminal index
	function automatic logic pick(input trig_src_t src, input logic [TERM_W-1:0] term,
			input logic [NS-1:0] v);
		logic r;
		r = 1'h0;
		case (src)
			SRC_TERMINAL: r = v[term];
			SRC_COUNTER: r = v[NUM_TERMS + IDX_COUNTER];
			SRC_ANALOG: r = v[NUM_TERMS + IDX_ANALOG];
			default: r = 1'h0;
		endcase
		return r;
	endfunction : pick

	// Convert spacing: conversion time plus padding, or even split
	function automatic logic [CNT_W-1:0] gap_of(input cfg_t c);
		logic [CNT_W-1:0] pad;
		logic [CNT_W-1:0] even;
		pad = c.conv_cycles + CNT_W'(SETTLE_PAD_CYCLES);
		even = (c.scan_chans == '0) ? pad : c.timebase_div / CNT_W'(c.scan_chans);
		if (even < pad)
			pad = even;
		if (pad == '0)
			pad = CNT_W'(1);
		return pad;
	endfunction : gap_of

	// Fastest oversample timebase among the requested ones
	function automatic oversample_t fastest(input logic [RATE_W-1:0] m);
		oversample_t r;
		r = OS_13M1072;
		if (m[OS_13M1072])
			r = OS_13M1072;
		else if (m[OS_12M8])
			r = OS_12M8;
		else if (m[OS_10M])
			r = OS_10M;
		return r;
	endfunction : fastest

	assign rise = q.s2 & ~q.s3;
	assign fall = ~q.s2 & q.s3;
	assign acquiring = q.fsm == ST_RUN || q.fsm == ST_POST;

	always_comb begin
		logic tick, start_ev, ref_ev, pause_lvl, sample_now, stop;
		d = q;
		tick = 1'h0;
		start_ev = 1'h0;
		ref_ev = 1'h0;
		pause_lvl = 1'h0;
		sample_now = 1'h0;
		stop = 1'h0;
		d.s1 = {timebase_in, analog_event, counter_out, terminal_in};
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.sc_pulse = 1'h0;
		d.st_pulse = 1'h0;
		d.rt_pulse = 1'h0;
		d.conv_pulse = 1'h0;
		d.ssh_pulse = 1'h0;
		d.sync_pulse = 1'h0;
		d.slow_conv = 1'h0;

		tick = cfg.timebase_ext ? rise[NUM_TERMS + IDX_TIMEBASE] : 1'h1;
		case (cfg.start_src)
			SRC_SOFTWARE: start_ev = sw_start;
			SRC_TIME: start_ev = device_time >= cfg.trig_time;
			SRC_ANALOG: start_ev = pick(cfg.start_src, cfg.start_term, rise);
			default: start_ev = cfg.start_falling ?
				pick(cfg.start_src, cfg.start_term, fall) :
				pick(cfg.start_src, cfg.start_term, rise);
		endcase
		ref_ev = cfg.ref_falling ? pick(cfg.ref_src, cfg.ref_term, fall) :
			pick(cfg.ref_src, cfg.ref_term, rise);
		pause_lvl = pick(cfg.pause_src, cfg.pause_term, q.s2);
		d.paused = cfg.pause_en && (pause_lvl == cfg.pause_high);

		case (q.fsm)
			ST_IDLE, ST_DONE: begin
				if (commit) begin
					d.fsm = ST_WAIT_START;
					d.smp_cnt = '0;
					d.pre_cnt = '0;
					d.ref_armed = 1'h0;
					d.triggered = 1'h0;
					d.tb_cnt = '0;
					d.os_sel = fastest(cfg.dsm_rates);
					d.sync_pulse = cfg.dsm_en;
					d.slow_conv = cfg.slow_en;
					d.slow_cnt = cfg.slow_period;
					d.slow_reuse = 1'h0;
				end
			end
			ST_WAIT_START: begin
				if (sw_stop) begin
					d.fsm = ST_IDLE;
				end else if (start_ev) begin
					d.st_pulse = 1'h1;
					d.delay_cnt = cfg.start_delay;
					d.fsm = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (sw_stop) begin
					d.fsm = ST_IDLE;
				end else if (q.delay_cnt == '0 || cfg.timebase_ext) begin
					d.fsm = ST_RUN;
					d.tb_cnt = cfg.timebase_div - 1'b1;
				end else begin
					d.delay_cnt = q.delay_cnt - 1'b1;
				end
			end
			ST_RUN, ST_POST: begin
				if (tick && !d.paused) begin
					if (q.tb_cnt >= cfg.timebase_div - 1'b1) begin
						d.tb_cnt = '0;
						sample_now = 1'h1;
					end else begin
						d.tb_cnt = q.tb_cnt + 1'b1;
					end
				end
				if (sample_now) begin
					d.sc_pulse = 1'h1;
					d.ssh_pulse = cfg.ssh_en;
					d.conv_left = cfg.scan_chans;
					d.conv_chan = '0;
					d.conv_cnt = '0;
					d.conv_gap = gap_of(cfg);
					d.smp_cnt = q.smp_cnt + 1'b1;
					if (q.pre_cnt < cfg.pretrig_count)
						d.pre_cnt = q.pre_cnt + 1'b1;
					if (cfg.slow_en) begin
						d.slow_reuse = q.slow_cnt != '0;
						d.slow_conv = q.slow_cnt == '0;
					end
					if (q.fsm == ST_POST) begin
						d.post_cnt = q.post_cnt - 1'b1;
						stop = q.post_cnt <= CNT_W'(1);
					end else if (cfg.finite && !cfg.ref_en) begin
						stop = d.smp_cnt >= cfg.sample_count;
					end
				end
				// Armed only once the pretrigger samples are in
				d.ref_armed = cfg.ref_en && cfg.finite && q.fsm == ST_RUN &&
					q.pre_cnt >= cfg.pretrig_count;
				if (q.fsm == ST_RUN && q.ref_armed && ref_ev) begin
					d.rt_pulse = 1'h1;
					d.triggered = 1'h1;
					d.ref_armed = 1'h0;
					d.post_cnt = cfg.buffer_size - cfg.pretrig_count;
					d.fsm = ST_POST;
					if (d.post_cnt == '0)
						stop = 1'h1;
				end
				if (stop || sw_stop)
					d.fsm = ST_DONE;
			end
			default: d.fsm = ST_IDLE;
		endcase

		// Slow module conversion interval
		if (d.slow_conv)
			d.slow_cnt = cfg.slow_period;
		else if (q.slow_cnt != '0)
			d.slow_cnt = q.slow_cnt - 1'b1;

		// Convert pulse sequencer for the scanned module
		if (q.conv_left != '0 && !sample_now) begin
			if (q.conv_cnt == '0) begin
				d.conv_pulse = 1'h1;
				// Index of the channel converted by this pulse, counting up from zero
				d.conv_chan = cfg.scan_chans - q.conv_left;
				d.conv_left = q.conv_left - 1'b1;
				d.conv_cnt = q.conv_gap - 1'b1;
			end else begin
				d.conv_cnt = q.conv_cnt - 1'b1;
			end
		end

		for (int i = 0; i < NUM_TERMS; i++) begin
			case (term_route[i])
				ROUTE_SAMPLE: d.term_out[i] = d.sc_pulse;
				ROUTE_START: d.term_out[i] = d.st_pulse;
				ROUTE_REF: d.term_out[i] = d.rt_pulse;
				default: d.term_out[i] = 1'h0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n_s) begin
		if (!rst_n_s)
			q <= '0;
		else
			q <= d;
	end

	// Oldest word dropped so pre and posttrigger samples keep landing
	assign discard = acquiring && cfg.ref_en && fifo_full && adc_valid;
	assign adc_ready = acquiring && fifo_in_ready;
	assign out_valid = fifo_valid && !discard;

	sample_fifo #(
		.WIDTH(SAMPLE_W),
		.DEPTH(BUF_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_n_s),
		.in_valid(adc_valid && acquiring),
		.in_ready(fifo_in_ready),
		.in_data(adc_data),
		.out_valid(fifo_valid),
		.out_ready(out_ready || discard),
		.out_data(out_data),
		.full(fifo_full)
	);

	assign terminal_out = q.term_out;
	assign sample_clock = q.sc_pulse;
	assign start_trig_out = q.st_pulse;
	assign ref_trig_out = q.rt_pulse;
	assign convert_pulse = q.conv_pulse;
	assign convert_chan = q.conv_chan;
	assign ssh_sample = q.ssh_pulse;
	assign dsm_sync = q.sync_pulse;
	assign os_sel = q.os_sel;
	assign slow_convert = q.slow_conv;
	assign slow_reuse = q.slow_reuse;
	assign status = '{busy: q.fsm != ST_IDLE && q.fsm != ST_DONE,
		ref_armed: q.ref_armed, triggered: q.triggered,
		done: q.fsm == ST_DONE, paused: q.paused};

endmodule : ai_timing_engine

// *** logic/ai_timing_pkg.sv ***
// Shared types and constants for the analog input timing engine
package ai_timing_pkg;

	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int SETTLE_PAD_US = 10;
	localparam int SETTLE_PAD_CYCLES = SETTLE_PAD_US * CYC_PER_US;
	localparam int NUM_ENGINES = 8;
	localparam int CNT_W = 24;
	localparam int TERM_W = 3;
	localparam int CH_W = 5;
	localparam int TIME_W = 64;
	localparam int RATE_W = 3;
	localparam int SAMPLE_W = 24;
	localparam int FIFO_DEPTH = 16;

	// Index of extra synchronised inputs above the terminal bits
	localparam int IDX_COUNTER = 0;
	localparam int IDX_ANALOG = 1;
	localparam int IDX_TIMEBASE = 2;
	localparam int EXTRA_INPUTS = 3;

	typedef enum logic [2:0] {
		SRC_SOFTWARE,
		SRC_TERMINAL,
		SRC_COUNTER,
		SRC_ANALOG,
		SRC_TIME
	} trig_src_t;

	typedef enum logic [1:0] {
		ROUTE_NONE,
		ROUTE_SAMPLE,
		ROUTE_START,
		ROUTE_REF
	} route_t;

	// Oversample timebases 10 MHz, 12.8 MHz, 13.1072 MHz, slowest first
	typedef enum logic [1:0] {
		OS_10M,
		OS_12M8,
		OS_13M1072
	} oversample_t;

	typedef struct packed {
		logic timebase_ext;
		logic [CNT_W-1:0] timebase_div;
		logic finite;
		logic ref_en;
		logic [CNT_W-1:0] sample_count;
		logic [CNT_W-1:0] pretrig_count;
		logic [CNT_W-1:0] buffer_size;
		logic [CNT_W-1:0] start_delay;
		trig_src_t start_src;
		logic [TERM_W-1:0] start_term;
		logic start_falling;
		logic [TIME_W-1:0] trig_time;
		trig_src_t ref_src;
		logic [TERM_W-1:0] ref_term;
		logic ref_falling;
		logic pause_en;
		trig_src_t pause_src;
		logic [TERM_W-1:0] pause_term;
		logic pause_high;
		logic [CH_W-1:0] scan_chans;
		logic [CNT_W-1:0] conv_cycles;
		logic ssh_en;
		logic dsm_en;
		logic [RATE_W-1:0] dsm_rates;
		logic slow_en;
		logic [CNT_W-1:0] slow_period;
	} cfg_t;

	typedef struct packed {
		logic busy;
		logic ref_armed;
		logic triggered;
		logic done;
		logic paused;
	} status_t;

endpackage : ai_timing_pkg

// *** logic/sample_fifo.sv ***
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ns
module sample_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic full
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("sample_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] cnt;
	} fifo_state_t;

	fifo_state_t q, d;
	logic push, pop;

	assign full = q.cnt == (AW+1)'(DEPTH);
	assign out_valid = q.cnt != '0;
	// A full FIFO still takes a word when one leaves in the same cycle
	assign in_ready = !full || out_ready;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = q.mem[q.rd];

	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wr] = in_data;
			d.wr = q.wr + 1'b1;
		end
		if (pop)
			d.rd = q.rd + 1'b1;
		if (push && !pop)
			d.cnt = q.cnt + 1'b1;
		else if (pop && !push)
			d.cnt = q.cnt - 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

endmodule : sample_fifo

// *** test/adc_module_model.sv ***
// Plug-in converter model answering conversion pulses on the sample stream
`timescale 1ns/1ns
module adc_module_model
	import ai_timing_pkg::*;
(
	input wire logic clock,
	input wire logic convert_pulse,
	input wire logic ssh_sample,
	input wire logic slow,
	input wire logic adc_ready,
	output logic adc_valid = 1'b0,
	output logic [SAMPLE_W-1:0] adc_data = '0
);
	int pending = 0;
	int wait_cnt = 0;
	logic [SAMPLE_W-1:0] word = '0;
	always @(posedge clock) begin
		if (adc_valid && adc_ready) begin
			word = word + 24'h1;
			pending = pending - 1;
			wait_cnt = slow ? 3 : 0;
		end
		pending = pending + convert_pulse + ssh_sample;
		if (wait_cnt > 0)
			wait_cnt = wait_cnt - 1;
		adc_valid <= pending > 0 && wait_cnt == 0;
		// Idle bus shows inverted data
		adc_data <= (pending > 0 && wait_cnt == 0) ? word : ~word;
	end
endmodule : adc_module_model

// *** test/ai_timing_engine_props.sv ***
// Concurrent checks on the timing engine ports
`timescale 1ns/1ns
module ai_timing_engine_props
	import ai_timing_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire cfg_t cfg,
	input wire logic commit,
	input wire logic sample_clock,
	input wire logic start_trig_out,
	input wire logic ref_trig_out,
	input wire logic convert_pulse,
	input wire logic [CH_W-1:0] convert_chan,
	input wire logic ssh_sample,
	input wire logic dsm_sync,
	input wire logic adc_ready,
	input wire status_t status
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_scan_sample;
		sample_clock && cfg.scan_chans != 5'h0;
	endsequence
	sequence s_first_conv;
		convert_pulse && convert_chan == 5'h0;
	endsequence
	a_first_convert: assert property (s_scan_sample |=> s_first_conv)
		else $error("no channel 0 convert after sample");
	a_ssh_with_sample: assert property (ssh_sample == (sample_clock && cfg.ssh_en))
		else $error("hold pulse not paired with sample");
	a_paused_no_sample: assert property (status.paused && $past(status.paused) |-> !sample_clock)
		else $error("sample while paused");
	a_ref_when_armed: assert property (ref_trig_out |-> $past(status.ref_armed))
		else $error("reference accepted before armed");
	a_ref_finite_only: assert property (ref_trig_out |-> cfg.ref_en && cfg.finite)
		else $error("reference outside finite reference mode");
	a_sync_on_commit: assert property (dsm_sync |-> $past(commit) && cfg.dsm_en)
		else $error("sync pulse without commit");
	a_start_single: assert property (start_trig_out |=> !start_trig_out [*8])
		else $error("start trigger repeated");
	a_idle_no_take: assert property (!status.busy |-> !adc_ready)
		else $error("samples taken while idle");
endmodule : ai_timing_engine_props

bind ai_timing_engine ai_timing_engine_props i_props (.clock, .reset_n, .cfg, .commit,
	.sample_clock, .start_trig_out, .ref_trig_out, .convert_pulse, .convert_chan, .ssh_sample,
	.dsm_sync, .adc_ready, .status);

// *** test/tb_ai_timing_engine.sv ***
// Self-checking bench for the analog input timing engine
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_ai_timing_engine;
	import ai_timing_pkg::*;
	logic clock, reset_n, commit, sw_start, sw_stop, analog_event, slow, out_ready;
	logic sample_clock, start_trig_out, ref_trig_out, convert_pulse, ssh_sample, dsm_sync;
	logic slow_convert, slow_reuse, adc_valid, adc_ready, out_valid;
	logic [7:0] terminal_in, terminal_out;
	logic [CH_W-1:0] convert_chan;
	logic [SAMPLE_W-1:0] adc_data, out_data, exp_word;
	logic [TIME_W-1:0] device_time = '0, t_start, t_first;
	route_t [7:0] term_route;
	oversample_t os_sel;
	status_t status;
	cfg_t cfg;
	trig_src_t srcs [2] = '{SRC_ANALOG, SRC_TIME};
	int miscompares, checks_done, n_samp, n_conv, n_route, n_start, n_ref, n_sync, n_slow;
	int n_block, s_ref, n_hold;
	ai_timing_engine i_dut (.clock, .reset_n, .cfg, .commit, .sw_start, .sw_stop, .terminal_in,
		.counter_out(1'b0), .analog_event, .timebase_in(1'b0), .device_time, .term_route,
		.terminal_out, .sample_clock, .start_trig_out, .ref_trig_out, .convert_pulse,
		.convert_chan, .ssh_sample, .dsm_sync, .os_sel, .slow_convert, .slow_reuse, .adc_valid,
		.adc_ready, .adc_data, .out_valid, .out_ready, .out_data, .status);
	adc_module_model i_model (.clock, .convert_pulse, .ssh_sample, .slow, .adc_ready,
		.adc_valid, .adc_data);
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		device_time <= device_time + 64'h1;
		if (ref_trig_out) s_ref = n_samp + sample_clock;
		if (start_trig_out) t_start = device_time;
		if (sample_clock && n_samp == 0) t_first = device_time;
		n_samp += sample_clock;
		n_conv += convert_pulse;
		n_route += terminal_out[3];
		n_start += start_trig_out;
		n_ref += ref_trig_out;
		n_sync += dsm_sync;
		n_slow += slow_convert;
		n_block += adc_valid && !adc_ready && status.busy;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task automatic go();
		{n_samp, n_conv, n_route, n_start, n_ref, n_sync, n_slow, n_block} = '0;
		commit = 1;
		cyc(1);
		commit = 0;
		cyc(2);
	endtask : go
	task automatic await_done(input int lim);
		for (int i = 0; i < lim && status.done !== 1'b1; i++) cyc(1);
		// Let the pulse that ends the task be counted
		cyc(1);
		`CHK("done", 1'b1, status.done)
	endtask : await_done
	task automatic drain(input int n);
		for (int k = 0; k < n; k++) begin
			for (int i = 0; i < 200 && out_valid !== 1'b1; i++) cyc(1);
			`CHK("out_data", exp_word, out_data)
			exp_word++;
			cyc(1);
		end
	endtask : drain
	task automatic conclude();
		$display("Mismatches %0d of %0d checks", miscompares, checks_done);
		if (miscompares == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	initial begin
		#500000;
		miscompares++;
		conclude();
	end
	initial begin
		reset_n = 0;
		{commit, sw_start, sw_stop, analog_event, slow, out_ready} = '0;
		terminal_in = '0;
		term_route = '{default: ROUTE_NONE};
		cfg = '0;
		cyc(10);
		`CHK("idle ready", 1'b0, adc_ready)
		reset_n = 1;
		cyc(3);
		cfg.timebase_div = 24'h14;
		cfg.ssh_en = 1;
		cfg.dsm_en = 1;
		cfg.dsm_rates = 3'h3;
		cfg.slow_en = 1;
		cfg.slow_period = 24'hfff;
		term_route[3] = ROUTE_SAMPLE;
		go();
		`CHK("dsm_sync", 1, n_sync)
		`CHK("slow_convert", 1, n_slow)
		`CHK("os_sel", OS_12M8, os_sel)
		sw_start = 1;
		cyc(1);
		sw_start = 0;
		cyc(400);
		`CHK("full refuses", 1'b1, n_block > 0)
		`CHK("slow reuse", 1'b1, slow_reuse)
		`CHK("routed", n_samp, n_route)
		exp_word = '0;
		out_ready = 1;
		drain(24);
		sw_stop = 1;
		cyc(1);
		sw_stop = 0;
		await_done(5);
		out_ready = 0;
		slow = 1;
		cfg.dsm_en = 0;
		cfg.slow_en = 0;
		cfg.finite = 1;
		cfg.ref_en = 1;
		cfg.pretrig_count = 24'h4;
		cfg.buffer_size = 24'h8;
		cfg.ref_src = SRC_TERMINAL;
		cfg.ref_term = 3'h2;
		cfg.start_src = SRC_TERMINAL;
		cfg.start_falling = 1;
		cfg.pause_en = 1;
		cfg.pause_src = SRC_TERMINAL;
		cfg.pause_term = 3'h1;
		cfg.pause_high = 1;
		go();
		terminal_in[0] = 1;
		cyc(10);
		`CHK("rising start", 0, n_start)
		terminal_in[0] = 0;
		cyc(10);
		`CHK("falling start", 1, n_start)
		terminal_in[2] = 1;
		cyc(10);
		terminal_in[2] = 0;
		cyc(600);
		`CHK("early ref", 0, n_ref)
		terminal_in[1] = 1;
		cyc(10);
		n_hold = n_samp;
		cyc(100);
		`CHK("paused flag", 1'b1, status.paused)
		`CHK("paused", n_hold, n_samp)
		terminal_in[1] = 0;
		cyc(60);
		`CHK("resumed", 1'b1, n_samp > n_hold)
		terminal_in[2] = 1;
		await_done(400);
		`CHK("ref", 1, n_ref)
		`CHK("post samples", 4, n_samp - s_ref)
		`CHK("triggered", 1'b1, status.triggered)
		exp_word = i_model.word - 24'h10;
		out_ready = 1;
		drain(16);
		terminal_in[2] = 0;
		cfg.ref_en = 0;
		cfg.pause_en = 0;
		cfg.ssh_en = 0;
		cfg.sample_count = 24'h3;
		cfg.scan_chans = 5'h2;
		cfg.conv_cycles = 24'h2;
		cfg.start_delay = 24'h5;
		analog_event = 1;
		cyc(5);
		foreach (srcs[j]) begin
			cfg.start_src = srcs[j];
			cfg.trig_time = device_time + 64'h32;
			go();
			cyc(20);
			`CHK("early start", 0, n_start)
			analog_event = 0;
			cyc(5);
			`CHK("no fall start", 0, n_start)
			analog_event = 1;
			cyc(40);
			`CHK("start", 1, n_start)
			await_done(200);
			cyc(20);
			`CHK("samples", 3, n_samp)
			`CHK("converts", 6, n_conv)
			`CHK("first delay", 64'h7, t_first - t_start)
		end
		`CHK("time", 1'b1, t_start >= cfg.trig_time && t_start < cfg.trig_time + 4)
		conclude();
	end
endmodule : tb_ai_timing_engine
